// >>> core/rx_ds3_alarm_parity_monitor.sv
`default_nettype none
// Overview of operation
// - Idle declaration raises idle change interrupt
// - Idle alarm clears when counter reaches zero
// - Both X-bits zero declares far-end fail
// - Status bit 4 mirrors far-end fail
// - Far-end fail change sets interrupt flag
// - X-bits one clear far-end fail
// - All-ones block error field counts nothing
// - Other block error values increment counter
// - Status bit 3 copies application-id bit
// - Application-id change sets flag bit 2
// - Check payload parity against next P-bits
// - Parity mismatch raises P-bit interrupt
// - Parity mismatch makes transmitter send error code
// - Parity errors increment parity counter
// - Counter read returns count then resets
// - Two errors in five frames declare out-of-frame
module rx_ds3_alarm_parity_monitor (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	// Register bus
	input wire rx_alarm_pkg::apb_req_t i_apb,
	output rx_alarm_pkg::apb_rsp_t o_apb,
	// Receive overhead and payload from the framer
	input wire rx_alarm_pkg::rx_overhead_t i_oh,
	input wire logic i_payload_valid,
	input wire logic i_payload_bit,
	// Alarm levels
	output logic o_idle_alarm_flag,
	output logic o_far_end_fail_flag,
	output logic o_oof,
	output logic o_app_id_bit_copy,
	output logic o_int_req,
	// Block error code for the local transmitter
	output logic [2:0] o_tx_far_end_block_error_field
);
	import rx_alarm_pkg::*;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic setup, access, rd_acc, wr_acc, hit_any, perr, fe;
	logic fop_q, fop_d, ferf_q, ferf_d, aic_q, aic_d, oof_q, oof_d;
	logic [2:0] febe_q, febe_d, tx_q, tx_d;
	logic [5:0] idle_cnt_q, idle_cnt_d;
	alarm_state_t idle_q, idle_d;
	logic [OOF_WIN-1:0] hist_q, hist_d;
	logic [7:0] flags_q, flags_d, set_v, clr_v, status_v, cfg_v;
	logic [DATA_W-1:0] rdata_q, rdata_d;
	logic par_snap, par_take, febe_snap, febe_take, febe_inc;
	logic [CNT_W-1:0] par_cnt, par_hold, febe_cnt, febe_hold;

	assign fe = i_oh.frame_end;
	assign setup = i_apb.psel && !i_apb.penable;
	assign access = i_apb.psel && i_apb.penable;
	assign rd_acc = access && !i_apb.pwrite;
	assign wr_acc = access && i_apb.pwrite;

	// ------------------------------------------------------------
	// Parity check and event counters
	// ------------------------------------------------------------
	parity_checker u_parity (
		.i_core_clk(i_core_clk),
		.i_reset_n(i_reset_n),
		.i_payload_valid(i_payload_valid),
		.i_payload_bit(i_payload_bit),
		.i_frame_end(fe),
		.i_p_bits(i_oh.p_bits),
		.o_parity_error(perr)
	);

	// Snapshot at setup, release at access: both bytes are coherent
	assign par_snap = setup && !i_apb.pwrite && reg_hit(i_apb.paddr, IDX_PAR_MSB);
	assign par_take = rd_acc && reg_hit(i_apb.paddr, IDX_PAR_MSB);
	assign febe_snap = setup && !i_apb.pwrite && reg_hit(i_apb.paddr, IDX_FEBE_MSB);
	assign febe_take = rd_acc && reg_hit(i_apb.paddr, IDX_FEBE_MSB);
	assign febe_inc = fe && i_oh.febe != FEBE_CLEAN;

	event_counter #(.WIDTH(CNT_W)) u_par_cnt (
		.i_core_clk(i_core_clk),
		.i_reset_n(i_reset_n),
		.i_inc(perr),
		.i_snap(par_snap),
		.i_take(par_take),
		.o_count(par_cnt),
		.o_snap(par_hold)
	);

	event_counter #(.WIDTH(CNT_W)) u_febe_cnt (
		.i_core_clk(i_core_clk),
		.i_reset_n(i_reset_n),
		.i_inc(febe_inc),
		.i_snap(febe_snap),
		.i_take(febe_take),
		.o_count(febe_cnt),
		.o_snap(febe_hold)
	);

	// ------------------------------------------------------------
	// Alarm state, updated at each frame boundary
	// ------------------------------------------------------------
	always_comb begin
		ferf_d = ferf_q;
		aic_d = aic_q;
		febe_d = febe_q;
		tx_d = tx_q;
		hist_d = hist_q;
		idle_cnt_d = idle_cnt_q;
		idle_d = idle_q;
		if (fe) begin
			if (i_oh.x_bits == X_FERF) begin
				ferf_d = 1'b1;
			end else if (i_oh.x_bits == X_CLEAR) begin
				ferf_d = 1'b0;
			end
			aic_d = i_oh.aic;
			febe_d = i_oh.febe;
			tx_d = perr ? FEBE_ERR_CODE : FEBE_CLEAN;
			hist_d = {hist_q[OOF_WIN-2:0], perr};
			// Up/down counter saturates at both ends
			if (i_oh.idle_frame) begin
				idle_cnt_d = (idle_cnt_q == IDLE_MAX) ? IDLE_MAX : idle_cnt_q + 6'h01;
			end else begin
				idle_cnt_d = (idle_cnt_q == IDLE_ZERO) ? IDLE_ZERO : idle_cnt_q - 6'h01;
			end
			if (idle_cnt_d == IDLE_MAX) begin
				idle_d = ALARM_ON;
			end else if (idle_cnt_d == IDLE_ZERO) begin
				idle_d = ALARM_OFF;
			end
		end
		// Out-of-frame on parity only while that option is on
		oof_d = fop_q && (ones(hist_d) >= OOF_LIMIT);
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ferf_q <= 1'b0;
			aic_q <= 1'b0;
			febe_q <= 3'h0;
			tx_q <= FEBE_CLEAN;
			hist_q <= '0;
			idle_cnt_q <= IDLE_ZERO;
			idle_q <= ALARM_OFF;
			oof_q <= 1'b0;
		end else begin
			ferf_q <= ferf_d;
			aic_q <= aic_d;
			febe_q <= febe_d;
			tx_q <= tx_d;
			hist_q <= hist_d;
			idle_cnt_q <= idle_cnt_d;
			idle_q <= idle_d;
			oof_q <= oof_d;
		end
	end

	// ------------------------------------------------------------
	// Interrupt flags: clear-on-read of only the bits reported
	// ------------------------------------------------------------
	always_comb begin
		set_v = 8'h00;
		set_v[IRQ_IDLE_BIT] = idle_d != idle_q;
		set_v[IRQ_FERF_BIT] = ferf_d != ferf_q;
		set_v[IRQ_AIC_BIT] = aic_d != aic_q;
		set_v[IRQ_OOF_BIT] = oof_d != oof_q;
		set_v[IRQ_PBIT_BIT] = perr;
		// Bits that were returned in the read data are the ones cleared
		clr_v = (rd_acc && reg_hit(i_apb.paddr, IDX_IRQ)) ? rdata_q[7:0] : 8'h00;
		flags_d = (flags_q & ~clr_v) | set_v;
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			flags_q <= IRQ_RESET;
		end else begin
			flags_q <= flags_d;
		end
	end

	// ------------------------------------------------------------
	// Register read and write decode
	// ------------------------------------------------------------
	always_comb begin
		status_v = STATUS_RESET;
		status_v[ST_FERF_BIT] = ferf_q;
		status_v[ST_AIC_BIT] = aic_q;
		status_v[2:0] = febe_q;
		cfg_v = 8'h00;
		cfg_v[CFG_IDLE_BIT] = idle_q == ALARM_ON;
		cfg_v[CFG_OOF_BIT] = oof_q;
		cfg_v[CFG_FOP_BIT] = fop_q;
		hit_any = 1'b1;
		rdata_d = rdata_q;
		if (reg_hit(i_apb.paddr, IDX_CFG)) begin
			rdata_d = {24'h0, cfg_v};
		end else if (reg_hit(i_apb.paddr, IDX_STATUS)) begin
			rdata_d = {24'h0, status_v};
		end else if (reg_hit(i_apb.paddr, IDX_IRQ)) begin
			rdata_d = {24'h0, flags_q};
		end else if (reg_hit(i_apb.paddr, IDX_PAR_MSB)) begin
			rdata_d = {24'h0, par_cnt[15:8]};
		end else if (reg_hit(i_apb.paddr, IDX_PAR_LSB)) begin
			rdata_d = {24'h0, par_hold[7:0]};
		end else if (reg_hit(i_apb.paddr, IDX_FEBE_MSB)) begin
			rdata_d = {24'h0, febe_cnt[15:8]};
		end else if (reg_hit(i_apb.paddr, IDX_FEBE_LSB)) begin
			rdata_d = {24'h0, febe_hold[7:0]};
		end else begin
			hit_any = 1'b0;
			rdata_d = '0;
		end
		// Data is captured only in the setup cycle
		if (!setup) begin
			rdata_d = rdata_q;
		end
		fop_d = fop_q;
		if (wr_acc && reg_hit(i_apb.paddr, IDX_CFG)) begin
			fop_d = i_apb.pwdata[CFG_FOP_BIT];
		end
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rdata_q <= '0;
			fop_q <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			fop_q <= fop_d;
		end
	end

	// Zero-wait slave; unmapped addresses answer with an error
	assign o_apb.prdata = rdata_q;
	assign o_apb.pready = 1'b1;
	assign o_apb.pslverr = access && !hit_any;

	assign o_idle_alarm_flag = idle_q == ALARM_ON;
	assign o_far_end_fail_flag = ferf_q;
	assign o_oof = oof_q;
	assign o_app_id_bit_copy = aic_q;
	assign o_int_req = |flags_q;
	assign o_tx_far_end_block_error_field = tx_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);

	AST_IDLE_IRQ: assert property ($rose(o_idle_alarm_flag) |-> flags_q[IRQ_IDLE_BIT])
		else $error("idle declared without flag");
	AST_IDLE_CLEAR: assert property ($fell(o_idle_alarm_flag) |-> idle_cnt_q == IDLE_ZERO)
		else $error("idle cleared early");
	AST_FERF_SET: assert property (fe && i_oh.x_bits == X_FERF |=> o_far_end_fail_flag)
		else $error("far-end fail not declared");
	AST_FERF_STATUS: assert property (setup && reg_hit(i_apb.paddr, IDX_STATUS)
		|=> rdata_q[ST_FERF_BIT] == $past(ferf_q)) else $error("status bit 4 wrong");
	AST_FERF_IRQ: assert property ($changed(ferf_q) |-> flags_q[IRQ_FERF_BIT])
		else $error("far-end fail change not flagged");
	AST_FERF_CLR: assert property (fe && i_oh.x_bits == X_CLEAR |=> !o_far_end_fail_flag)
		else $error("far-end fail not cleared");
	AST_FEBE_CLEAN: assert property (fe && i_oh.febe == FEBE_CLEAN && !febe_take
		|=> $stable(febe_cnt)) else $error("clean frame counted");
	AST_FEBE_CNT: assert property (fe && i_oh.febe != FEBE_CLEAN && !febe_take
		|=> febe_cnt == $past(febe_cnt) + 1'b1) else $error("block error missed");
	AST_AIC_COPY: assert property (fe |=> o_app_id_bit_copy == $past(i_oh.aic))
		else $error("app id bit not copied");
	AST_AIC_IRQ: assert property (fe && i_oh.aic != aic_q |=> flags_q[IRQ_AIC_BIT])
		else $error("app id change not flagged");
	AST_PERR_IRQ: assert property (perr |=> flags_q[IRQ_PBIT_BIT] ##1 1'b1)
		else $error("parity error not flagged");
	AST_TX_FEBE: assert property (perr |=> o_tx_far_end_block_error_field != FEBE_CLEAN)
		else $error("error code not sent");
	AST_PAR_CNT: assert property (perr && !par_take |=> par_cnt == $past(par_cnt) + 1'b1)
		else $error("parity error not counted");
	// Looks at the registered option and the next history, so a fresh write of the option cannot misfire
	AST_OOF: assert property (fop_q && ones(hist_d) >= OOF_LIMIT |=> o_oof)
		else $error("out-of-frame not declared");
	AST_RC_KEEP: assert property (rd_acc && reg_hit(i_apb.paddr, IDX_IRQ) && set_v != 8'h00
		|=> (flags_q & $past(set_v)) == $past(set_v)) else $error("event lost on read");

	// ------------------------------------------------------------
	// Further checks on alarm levels and the bus answer
	// ------------------------------------------------------------
	// A clean frame puts the clean code back toward the transmitter
	AST_TX_CLEAN: assert property (fe && !perr |=> o_tx_far_end_block_error_field == FEBE_CLEAN)
		else $error("clean code not restored");
	// Top of the up/down count means the idle alarm stands
	AST_IDLE_SET: assert property (idle_cnt_q == IDLE_MAX |-> o_idle_alarm_flag)
		else $error("idle not declared at top count");
	// Clearing the idle alarm is reported as a change too
	AST_IDLE_FALL_IRQ: assert property ($fell(o_idle_alarm_flag) |-> flags_q[IRQ_IDLE_BIT])
		else $error("idle clear not flagged");
	// Without the option the out-of-frame level cannot stay up
	AST_OOF_OPT: assert property (!fop_q |=> !o_oof)
		else $error("out-of-frame without option");
	// Status read in two steps: setup captures, access hands the word back
	sequence s_status_read;
		setup && !i_apb.pwrite && reg_hit(i_apb.paddr, IDX_STATUS) ##1 rd_acc;
	endsequence
	AST_AIC_STATUS: assert property (s_status_read |-> o_apb.prdata[ST_AIC_BIT] == $past(aic_q))
		else $error("status bit 3 wrong");
endmodule // rx_ds3_alarm_parity_monitor
`default_nettype wire

// >>> core/rx_alarm_pkg.sv
`default_nettype none
package rx_alarm_pkg;
	// ------------------------------------------------------------
	// Bus and register map (printed offsets are word indices)
	// ------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int CNT_W = 16;
	localparam logic [7:0] IDX_CFG = 8'h10;
	localparam logic [7:0] IDX_STATUS = 8'h11;
	localparam logic [7:0] IDX_IRQ = 8'h13;
	localparam logic [7:0] IDX_PAR_MSB = 8'h54;
	localparam logic [7:0] IDX_PAR_LSB = 8'h55;
	localparam logic [7:0] IDX_FEBE_MSB = 8'h58;
	localparam logic [7:0] IDX_FEBE_LSB = 8'h59;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] IRQ_RESET = 8'h00;
	// Field positions
	localparam int CFG_IDLE_BIT = 5;
	localparam int CFG_OOF_BIT = 4;
	localparam int CFG_FOP_BIT = 2;
	localparam int ST_FERF_BIT = 4;
	localparam int ST_AIC_BIT = 3;
	localparam int IRQ_IDLE_BIT = 4;
	localparam int IRQ_FERF_BIT = 3;
	localparam int IRQ_AIC_BIT = 2;
	localparam int IRQ_OOF_BIT = 1;
	localparam int IRQ_PBIT_BIT = 0;
	// ------------------------------------------------------------
	// Overhead codes and thresholds
	// ------------------------------------------------------------
	localparam logic [2:0] FEBE_CLEAN = 3'h7;
	localparam logic [2:0] FEBE_ERR_CODE = 3'h0;
	localparam logic [1:0] X_FERF = 2'h0;
	localparam logic [1:0] X_CLEAR = 2'h3;
	localparam logic [5:0] IDLE_MAX = 6'h3F;
	localparam logic [5:0] IDLE_ZERO = 6'h00;
	localparam int OOF_WIN = 5;
	localparam logic [2:0] OOF_LIMIT = 3'h2;

	typedef enum logic {ALARM_OFF = 1'b0, ALARM_ON = 1'b1} alarm_state_t;

	typedef struct packed {
		logic frame_end;
		logic idle_frame;
		logic [1:0] x_bits;
		logic [2:0] febe;
		logic aic;
		logic [1:0] p_bits;
	} rx_overhead_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [DATA_W-1:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_t;

	// Byte address match for a register index
	function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
		return a == {2'h0, idx, 2'h0};
	endfunction

	// Number of set bits in the error history window
	function automatic logic [2:0] ones(input logic [OOF_WIN-1:0] v);
		logic [2:0] n;
		n = 3'h0;
		for (int i = 0; i < OOF_WIN; i++) begin
			n = n + {2'h0, v[i]};
		end
		return n;
	endfunction
endpackage
`default_nettype wire

// >>> core/parity_checker.sv
`default_nettype none
module parity_checker (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	// Payload and frame boundary
	input wire logic i_payload_valid,
	input wire logic i_payload_bit,
	input wire logic i_frame_end,
	input wire logic [1:0] i_p_bits,
	// Result, valid in the frame_end cycle
	output logic o_parity_error
);
	import rx_alarm_pkg::*;

	logic acc_q, acc_d, prev_q, prev_d, have_q, have_d, acc_now;

	// ------------------------------------------------------------
	// Running even parity; the previous frame's result is kept
	// ------------------------------------------------------------
	always_comb begin
		acc_now = acc_q ^ (i_payload_valid & i_payload_bit);
		acc_d = acc_now;
		prev_d = prev_q;
		have_d = have_q;
		// No reference before the first full frame, so no false error
		o_parity_error = 1'b0;
		if (i_frame_end) begin
			o_parity_error = have_q && (i_p_bits != {prev_q, prev_q});
			prev_d = acc_now;
			have_d = 1'b1;
			acc_d = 1'b0;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			acc_q <= 1'b0;
			prev_q <= 1'b0;
			have_q <= 1'b0;
		end else begin
			acc_q <= acc_d;
			prev_q <= prev_d;
			have_q <= have_d;
		end
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);

	AST_PAR_MATCH: assert property (i_frame_end && have_q && i_p_bits == {prev_q, prev_q}
		|-> !o_parity_error) else $error("parity flagged on matching P-bits");
	AST_PAR_REF: assert property (i_frame_end |=> prev_q == $past(acc_now) && acc_q == 1'b0
		|| $past(i_payload_valid)) else $error("parity reference not taken");
endmodule // parity_checker
`default_nettype wire

// >>> core/event_counter.sv
`default_nettype none
module event_counter #(
	parameter int WIDTH = rx_alarm_pkg::CNT_W
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	// Event and read control
	input wire logic i_inc,
	input wire logic i_snap,
	input wire logic i_take,
	// Live and captured counts
	output logic [WIDTH-1:0] o_count,
	output logic [WIDTH-1:0] o_snap
);
	import rx_alarm_pkg::*;

	logic [WIDTH-1:0] cnt_q, cnt_d, snap_q, snap_d;

	// ------------------------------------------------------------
	// Reset-upon-read: subtract what was reported, keep the rest
	// ------------------------------------------------------------
	always_comb begin
		snap_d = i_snap ? cnt_q : snap_q;
		// Subtracting the snapshot keeps events seen after it
		cnt_d = cnt_q + WIDTH'(i_inc) - (i_take ? snap_q : '0);
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cnt_q <= '0;
			snap_q <= '0;
		end else begin
			cnt_q <= cnt_d;
			snap_q <= snap_d;
		end
	end

	assign o_count = cnt_q;
	assign o_snap = snap_q;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);

	sequence s_read;
		i_snap ##1 i_take;
	endsequence

	AST_CNT_RUR: assert property (s_read |=> cnt_q == $past(cnt_q) - $past(snap_q)
		+ WIDTH'($past(i_inc))) else $error("counter not reset by read");
	AST_CNT_INC: assert property (i_inc && !i_take |=> cnt_q == $past(cnt_q) + 1'b1)
		else $error("event not counted");
endmodule // event_counter
`default_nettype wire

// >>> bench/far_end_tx_model.sv
`default_nettype none
// ----------------------------------------
// Remote transmit framer model
// ----------------------------------------
module far_end_tx_model (
	// Clock
	input wire logic i_core_clk,
	// Line side toward the monitor
	output rx_alarm_pkg::rx_overhead_t o_oh,
	output logic o_payload_valid,
	output logic o_payload_bit
);
	timeunit 1ns;
	timeprecision 1ps;
	import rx_alarm_pkg::*;

	logic par_q;

	// Quiet line at time zero, parity history empty
	initial begin
		o_oh = '0;
		o_payload_valid = 1'b0;
		o_payload_bit = 1'b0;
		par_q = 1'b0;
	end

	// Eight payload bits, then one overhead cycle; gap lets the far end run slow
	task automatic send_frame(input logic [1:0] x, input logic [2:0] febe, input logic aic,
		input logic idle, input logic bad, input logic [7:0] data, input int gap);
		logic p;
		p = 1'b0;
		repeat (gap) @(posedge i_core_clk);
		for (int i = 0; i < 8; i++) begin
			@(posedge i_core_clk);
			o_payload_valid <= 1'b1;
			o_payload_bit <= data[i];
			p = p ^ data[i];
		end
		@(posedge i_core_clk);
		o_payload_valid <= 1'b0;
		o_payload_bit <= ~data[7];
		// Previous frame parity in both P-bits; bad corrupts only one of them
		o_oh <= {1'b1, idle, x, febe, aic, par_q, par_q ^ bad};
		par_q = p;
		@(posedge i_core_clk);
		// Overhead is stale now, so show its inverse rather than hold it
		o_oh <= {1'b0, ~o_oh[8:0]};
	endtask
endmodule // far_end_tx_model
`default_nettype wire

// >>> bench/testbench.sv
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import rx_alarm_pkg::*;

	// ----------------------------------------
	// Clock, reset and wiring
	// ----------------------------------------
	logic i_core_clk = 1'b0;
	logic i_reset_n = 1'b0;
	apb_req_t apb_q = '0;
	apb_rsp_t apb_rsp;
	rx_overhead_t oh;
	logic pv, pb, idle_f, ferf_f, oof, aic_f, irq, err;
	logic [2:0] tx_code;
	logic [31:0] rd;
	int failures = 0;
	int samples_checked = 0;
	int cycles = 0;

	always #2.5 i_core_clk = ~i_core_clk;

	rx_ds3_alarm_parity_monitor dut_u (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
		.i_apb(apb_q), .o_apb(apb_rsp), .i_oh(oh), .i_payload_valid(pv), .i_payload_bit(pb),
		.o_idle_alarm_flag(idle_f), .o_far_end_fail_flag(ferf_f), .o_oof(oof),
		.o_app_id_bit_copy(aic_f), .o_int_req(irq), .o_tx_far_end_block_error_field(tx_code));
	far_end_tx_model far_u (.i_core_clk(i_core_clk), .o_oh(oh), .o_payload_valid(pv),
		.o_payload_bit(pb));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic give_verdict();
		$display("checked %0d, failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	// One APB transfer; request held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
		@(posedge i_core_clk);
		apb_q <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {2'h0, idx, 2'h0}, pwdata: wd};
		@(posedge i_core_clk);
		apb_q.penable <= 1'b1;
		do @(posedge i_core_clk); while (apb_rsp.pready !== 1'b1);
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_q <= '0;
	endtask

	task automatic rdc(input logic [7:0] idx, input logic [31:0] exp, input string what);
		apb(1'b0, idx, 32'h0);
		check(rd, exp, what);
	endtask

	task automatic frames(input int n, input logic idle);
		repeat (n) far_u.send_frame(2'h3, 3'h7, 1'b0, idle, 1'b0, 8'hCC, 0);
		#1;
	endtask

	// ----------------------------------------
	// Frame table: overhead in, status, flags and error code out
	// ----------------------------------------
	typedef struct packed {
		logic [1:0] x;
		logic [2:0] febe;
		logic aic;
		logic bad;
		logic [7:0] data;
		logic [7:0] st;
		logic [7:0] fl;
		logic [2:0] tx;
	} row_t;
	row_t rows [5] = '{
		'{2'h3, 3'h7, 1'b0, 1'b0, 8'hA5, 8'h07, 8'h00, 3'h7},
		'{2'h0, 3'h7, 1'b0, 1'b0, 8'h01, 8'h17, 8'h08, 3'h7},
		'{2'h1, 3'h2, 1'b1, 1'b0, 8'h03, 8'h1A, 8'h04, 3'h7},
		'{2'h3, 3'h7, 1'b1, 1'b1, 8'h07, 8'h0F, 8'h09, 3'h0},
		'{2'h3, 3'h0, 1'b0, 1'b0, 8'hA5, 8'h00, 8'h04, 3'h7}
	};

	// Hang guard: the whole run needs well under this many cycles
	always @(posedge i_core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 10000) begin
			failures++;
			give_verdict();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge i_core_clk);
		i_reset_n <= 1'b1;
		foreach (rows[i]) begin
			far_u.send_frame(rows[i].x, rows[i].febe, rows[i].aic, 1'b0, rows[i].bad,
				rows[i].data, 2);
			#1;
			check({29'h0, tx_code}, {29'h0, rows[i].tx}, "tx code");
			check({31'h0, ferf_f}, {31'h0, rows[i].st[4]}, "fail flag");
			check({31'h0, aic_f}, {31'h0, rows[i].st[3]}, "aic copy");
			rdc(IDX_STATUS, {24'h0, rows[i].st}, "status");
			check({31'h0, irq}, {31'h0, |rows[i].fl}, "int req");
			rdc(IDX_IRQ, {24'h0, rows[i].fl}, "flags");
		end
		// MSB first snapshots the pair; a second pair read sees zero
		rdc(IDX_FEBE_MSB, 32'h0, "febe msb");
		rdc(IDX_FEBE_LSB, 32'h2, "febe lsb");
		rdc(IDX_PAR_MSB, 32'h0, "par msb");
		rdc(IDX_PAR_LSB, 32'h1, "par lsb");
		rdc(IDX_PAR_MSB, 32'h0, "par msb again");
		rdc(IDX_PAR_LSB, 32'h0, "par lsb again");
		// Second reset in mid-run, then read-only and unmapped accesses
		@(posedge i_core_clk);
		i_reset_n <= 1'b0;
		repeat (3) @(posedge i_core_clk);
		i_reset_n <= 1'b1;
		#1;
		check({29'h0, tx_code}, 32'h7, "tx reset");
		rdc(IDX_IRQ, {24'h0, IRQ_RESET}, "flags reset");
		apb(1'b1, IDX_STATUS, 32'hFF);
		rdc(IDX_STATUS, {24'h0, STATUS_RESET}, "status ro");
		apb(1'b0, 8'h20, 32'h0);
		check({31'h0, err}, 32'h1, "slverr");
		check(rd, 32'h0, "unmapped data");
		// Idle alarm: declared on the 63rd idle frame, cleared on the 63rd clean one
		frames(62, 1'b1);
		check({31'h0, idle_f}, 32'h0, "idle early");
		frames(1, 1'b1);
		check({31'h0, idle_f}, 32'h1, "idle set");
		rdc(IDX_IRQ, 32'h10, "idle flag");
		rdc(IDX_CFG, 32'h20, "cfg idle");
		frames(62, 1'b0);
		check({31'h0, idle_f}, 32'h1, "idle held");
		frames(1, 1'b0);
		check({31'h0, idle_f}, 32'h0, "idle clear");
		rdc(IDX_IRQ, 32'h10, "idle clear flag");
		// Framing on parity: two errors inside five frames
		apb(1'b1, IDX_CFG, 32'h4);
		rdc(IDX_CFG, 32'h4, "cfg fop");
		far_u.send_frame(2'h3, 3'h7, 1'b0, 1'b0, 1'b1, 8'h5A, 0);
		far_u.send_frame(2'h3, 3'h7, 1'b0, 1'b0, 1'b0, 8'h01, 0);
		#1;
		check({31'h0, oof}, 32'h0, "oof early");
		far_u.send_frame(2'h3, 3'h7, 1'b0, 1'b0, 1'b1, 8'h5A, 0);
		#1;
		check({31'h0, oof}, 32'h1, "oof set");
		rdc(IDX_IRQ, 32'h3, "oof flags");
		rdc(IDX_PAR_MSB, 32'h0, "par msb oof");
		rdc(IDX_PAR_LSB, 32'h2, "par lsb oof");
		give_verdict();
	end
endmodule // testbench
`default_nettype wire
